// ### rfm_defines.svh
// register offsets, reset values, field positions and timing counts
// Notes on behaviour
// RULE1 - power/field register resets to 0x01
// RULE2 - B7 standby: regulators on, receiver/transmitter off
// RULE3 - B6 bypasses decoders, keying drives modulation
// RULE4 - field active only while B5 set
// RULE5 - B4 selects half drive power
// RULE6 - B3 selects phase input, else amplitude
// RULE7 - B1 enables receiver and oscillator; the oscillator here follows chip enable only
// RULE8 - B0 selects 5 V supply range
// RULE9 - protocol register resets to 0x02
// RULE10 - B7 set skips receive CRC check
// RULE11 - raw path: subcarrier, or bits plus clock
// RULE12 - codes 0-3: coding and single-subcarrier rate
// RULE13 - codes 4-7: double-subcarrier, same bit order
// RULE14 - codes 8-11: proximity A rates
// RULE15 - codes 12-15: proximity B rates
// RULE16 - proximity code rate applies to reception
// RULE17 - host writes zero to reserved bits
// RULE18 - host writes only defined protocol codes
// RULE19 - protocol write reloads option registers 0x02-0x0B
// RULE20 - stop condition ends raw path, clears B6
`ifndef RFM_DEFINES_SVH
`define RFM_DEFINES_SVH
`define RFM_ADDR_PWR      5'h00
`define RFM_ADDR_PROTO    5'h01
`define RFM_PWR_RESET     8'h01
`define RFM_PROTO_RESET   8'h02
`define RFM_PWR_RSVD_MASK 8'h04
`define RFM_PWR_DIRECT    6
`define RFM_OPT_FIRST     5'h02
`define RFM_OPT_LAST      5'h0B
`define RFM_CODE_PROPR    5'h13
`define RFM_SYNC_STAGES   2
`endif

// ### rfm_pkg.sv
// types shared by the main configuration register bank
`default_nettype none
package rfm_pkg;
   // power and field control register layout
   typedef struct packed {
      logic stby;
      logic direct;
      logic field_drive_enable;
      logic drive_strength_half;
      logic phase_input_select;
      logic rsvd;
      logic rec_on;
      logic supply_range_select;
   } rfm_pwr_type;
   // protocol select register layout
   typedef struct packed {
      logic       rx_crc_off;
      logic       raw_bits;
      logic       reader_mode;
      logic [4:0] code;
   } rfm_proto_type;
   typedef enum logic [2:0] {
      RFM_VIC_SINGLE = 3'h0,
      RFM_VIC_DOUBLE = 3'h1,
      RFM_PROX_A     = 3'h2,
      RFM_PROX_B     = 3'h3,
      RFM_PROPR      = 3'h4,
      RFM_UNDEF      = 3'h7
   } rfm_family_type;
   // decoded protocol choice
   typedef struct packed {
      rfm_family_type family;
      logic [1:0]     rate;
      logic           coding_256;
   } rfm_info_type;
endpackage
`default_nettype wire

// ### rfm_proto_decode.sv
// decodes the protocol select code into family, rate and coding
`timescale 1ns/1ps
`default_nettype none
`include "rfm_defines.svh"
module rfm_proto_decode (
   input  wire logic [4:0]          code,
   output rfm_pkg::rfm_info_type    info
);
   // vicinity rate bit is code[1], coding bit is code[0]
   always_comb begin
      info.rate       = 2'h0;
      info.coding_256 = 1'b0;
      info.family     = rfm_pkg::RFM_UNDEF;
      case (code[4:2])
         3'h0: begin
            info.family     = rfm_pkg::RFM_VIC_SINGLE; // RULE12
            info.rate       = {1'b0, code[1]};
            info.coding_256 = code[0];
         end
         3'h1: begin
            info.family     = rfm_pkg::RFM_VIC_DOUBLE; // RULE13
            info.rate       = {1'b0, code[1]};
            info.coding_256 = code[0];
         end
         3'h2: begin
            info.family = rfm_pkg::RFM_PROX_A; // RULE14
            info.rate   = code[1:0];
         end
         3'h3: begin
            info.family = rfm_pkg::RFM_PROX_B; // RULE15
            info.rate   = code[1:0];
         end
         default: begin
            // anything else has no defined behaviour, except code 0x13
            if (code == `RFM_CODE_PROPR) begin
               info.family = rfm_pkg::RFM_PROPR;
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// ### rfm_main_cfg.sv
// main configuration registers: power/field control and protocol select
`timescale 1ns/1ps
`default_nettype none
`include "rfm_defines.svh"
module rfm_main_cfg (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                chip_en,
   input  wire logic                host_wr,
   input  wire logic                host_rd,
   input  wire logic                host_stop,
   input  wire logic [4:0]          host_addr,
   input  wire logic [7:0]          host_wdata,
   output logic      [7:0]          host_rdata,
   output logic                     host_rvalid,
   input  wire logic                am_input,
   input  wire logic                pm_input,
   input  wire logic                keying_input,
   input  wire logic                framer_mod,
   input  wire logic                dec_bit,
   input  wire logic                dec_bit_clk,
   input  wire logic                tx_rate_differs,
   input  wire logic [1:0]          tx_rate_sel,
   output logic                     standby,
   output logic                     rx_enable,
   output logic                     tx_enable,
   output logic                     osc_enable,
   output logic                     field_drive_enable,
   output logic                     drive_strength_half,
   output logic                     phase_input_select,
   output logic                     supply_range_select,
   output logic                     decoder_bypass,
   output logic                     mod_out,
   output logic                     raw_out,
   output logic                     raw_out_oe,
   output logic                     raw_clk_out,
   output logic                     raw_clk_oe,
   output logic                     crc_check_enable,
   output rfm_pkg::rfm_info_type    proto_info,
   output logic      [1:0]          rx_rate,
   output logic      [1:0]          tx_rate,
   output logic                     option_reload
);

   // reset release through two flops
   logic [1:0] rst_pipe_r;
   logic       rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe_r <= 2'h0;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end

   assign rst_sync_b = rst_pipe_r[1];

   // pin synchronisers: chip enable, am, pm, keying
   logic [3:0] pin_in;
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic       en_s;
   logic       am_s;
   logic       pm_s;
   logic       key_s;

   assign pin_in = {chip_en, am_input, pm_input, keying_input};

   generate
      for (genvar i = 0; i < 4; i++) begin : g_sync
         always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               pin_s1_r[i] <= 1'b0;
               pin_s2_r[i] <= 1'b0;
            end else begin
               pin_s1_r[i] <= pin_in[i];
               pin_s2_r[i] <= pin_s1_r[i];
            end
         end
      end
   endgenerate

   assign en_s  = pin_s2_r[3];
   assign am_s  = pin_s2_r[2];
   assign pm_s  = pin_s2_r[1];
   assign key_s = pin_s2_r[0];

   // register bank state
   rfm_pkg::rfm_pwr_type   pwr_r;
   rfm_pkg::rfm_pwr_type   pwr_nxt;
   rfm_pkg::rfm_proto_type proto_r;
   rfm_pkg::rfm_proto_type proto_nxt;
   logic                   reload_r;
   logic                   reload_nxt;
   logic [7:0]             rdata_r;
   logic [7:0]             rdata_nxt;
   logic                   rvalid_r;
   logic                   rvalid_nxt;
   logic                   wr_pwr;
   logic                   wr_proto;

   assign wr_pwr   = host_wr && (host_addr == `RFM_ADDR_PWR);
   assign wr_proto = host_wr && (host_addr == `RFM_ADDR_PROTO);

   // writes, stop handling and enable-low clear
   always_comb begin
      pwr_nxt    = pwr_r;
      proto_nxt  = proto_r;
      reload_nxt = 1'b0;
      if (wr_pwr) begin
         // reserved bit is dropped so it always reads zero
         pwr_nxt = host_wdata & ~`RFM_PWR_RSVD_MASK;
      end
      if (wr_proto) begin
         proto_nxt  = host_wdata;
         reload_nxt = 1'b1; // RULE19
      end
      if (host_stop) begin
         // stop wins over a write in the same cycle
         pwr_nxt[`RFM_PWR_DIRECT] = 1'b0; // RULE20
      end
      if (!en_s) begin
         pwr_nxt    = `RFM_PWR_RESET; // RULE1
         proto_nxt  = `RFM_PROTO_RESET; // RULE9
         reload_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pwr_r    <= `RFM_PWR_RESET; // RULE1
         proto_r  <= `RFM_PROTO_RESET; // RULE9
         reload_r <= 1'b0;
      end else begin
         pwr_r    <= pwr_nxt;
         proto_r  <= proto_nxt;
         reload_r <= reload_nxt;
      end
   end

   // read path: other addresses belong to other banks, read zero
   always_comb begin
      rdata_nxt  = rdata_r;
      rvalid_nxt = host_rd;
      if (host_rd) begin
         case (host_addr)
            `RFM_ADDR_PWR:   rdata_nxt = pwr_r;
            `RFM_ADDR_PROTO: rdata_nxt = proto_r;
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign host_rdata    = rdata_r;
   assign host_rvalid   = rvalid_r;
   assign option_reload = reload_r;

   // protocol decode
   rfm_pkg::rfm_info_type info;

   rfm_proto_decode u_decode (
      .code (proto_r.code),
      .info (info)
   );

   // control outputs, one flop behind the registers
   logic                  stby_nxt;
   logic                  rxen_nxt;
   logic                  txen_nxt;
   logic                  osc_nxt;
   logic                  mod_nxt;
   logic                  raw_nxt;
   logic                  raw_oe_nxt;
   logic                  rclk_nxt;
   logic                  rclk_oe_nxt;
   logic [1:0]            txr_nxt;
   logic                  stby_r;
   logic                  rxen_r;
   logic                  txen_r;
   logic                  osc_r;
   logic                  mod_r;
   logic                  raw_r;
   logic                  raw_oe_r;
   logic                  rclk_r;
   logic                  rclk_oe_r;
   logic [1:0]            txr_r;
   logic                  field_r;
   logic                  half_r;
   logic                  psel_r;
   logic                  supply_r;
   logic                  bypass_r;
   logic                  crc_r;
   logic [1:0]            rxr_r;
   rfm_pkg::rfm_info_type info_r;

   always_comb begin
      stby_nxt = pwr_r.stby; // RULE2
      // standby wins over the rx and tx enables; oscillator stays up
      txen_nxt = !pwr_r.stby && pwr_r.field_drive_enable; // RULE4
      rxen_nxt = !pwr_r.stby
                 && (pwr_r.field_drive_enable || pwr_r.rec_on); // RULE7
      osc_nxt  = en_s;
      // keying input replaces the framer in the raw path
      mod_nxt  = pwr_r.direct ? key_s : framer_mod; // RULE3
      raw_oe_nxt  = pwr_r.direct;
      rclk_oe_nxt = pwr_r.direct && proto_r.raw_bits; // RULE11
      if (proto_r.raw_bits) begin
         raw_nxt  = dec_bit; // RULE11
         rclk_nxt = dec_bit_clk;
      end else begin
         // subcarrier taken from the chosen receive input
         raw_nxt  = pwr_r.phase_input_select ? pm_s : am_s; // RULE6
         rclk_nxt = 1'b0;
      end
      // separate transmit rate only on proximity codes
      txr_nxt = info.rate;
      if (tx_rate_differs && (info.family == rfm_pkg::RFM_PROX_A
                              || info.family == rfm_pkg::RFM_PROX_B)) begin
         txr_nxt = tx_rate_sel; // RULE16
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         stby_r    <= 1'b0;
         rxen_r    <= 1'b0;
         txen_r    <= 1'b0;
         osc_r     <= 1'b0;
         mod_r     <= 1'b0;
         raw_r     <= 1'b0;
         raw_oe_r  <= 1'b0;
         rclk_r    <= 1'b0;
         rclk_oe_r <= 1'b0;
         txr_r     <= 2'h0;
         field_r   <= 1'b0;
         half_r    <= 1'b0;
         psel_r    <= 1'b0;
         supply_r  <= 1'b1;
         bypass_r  <= 1'b0;
         crc_r     <= 1'b1;
         rxr_r     <= 2'h1;
         info_r    <= '0;
      end else begin
         stby_r    <= stby_nxt;
         rxen_r    <= rxen_nxt;
         txen_r    <= txen_nxt;
         osc_r     <= osc_nxt;
         mod_r     <= mod_nxt;
         raw_r     <= raw_nxt;
         raw_oe_r  <= raw_oe_nxt;
         rclk_r    <= rclk_nxt;
         rclk_oe_r <= rclk_oe_nxt;
         txr_r     <= txr_nxt;
         field_r   <= pwr_r.field_drive_enable; // RULE4
         half_r    <= pwr_r.drive_strength_half; // RULE5
         psel_r    <= pwr_r.phase_input_select; // RULE6
         supply_r  <= pwr_r.supply_range_select; // RULE8
         bypass_r  <= pwr_r.direct; // RULE3
         crc_r     <= !proto_r.rx_crc_off; // RULE10
         rxr_r     <= info.rate; // RULE16
         info_r    <= info;
      end
   end

   assign standby             = stby_r;
   assign rx_enable           = rxen_r;
   assign tx_enable           = txen_r;
   assign osc_enable          = osc_r;
   assign mod_out             = mod_r;
   assign raw_out             = raw_r;
   assign raw_out_oe          = raw_oe_r;
   assign raw_clk_out         = rclk_r;
   assign raw_clk_oe          = rclk_oe_r;
   assign tx_rate             = txr_r;
   assign field_drive_enable  = field_r;
   assign drive_strength_half = half_r;
   assign phase_input_select  = psel_r;
   assign supply_range_select = supply_r;
   assign decoder_bypass      = bypass_r;
   assign crc_check_enable    = crc_r;
   assign rx_rate             = rxr_r;
   assign proto_info          = info_r;

   // checks on the bank
   pwr_reset_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE1
      !en_s |=> pwr_r == `RFM_PWR_RESET)
      else $error("power register not cleared by enable low");

   proto_reset_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE9
      !en_s |=> proto_r == `RFM_PROTO_RESET ##1 rx_rate == 2'h1)
      else $error("protocol register not cleared by enable low");

   standby_quiet_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE2
      pwr_r.stby |=> !rx_enable && !tx_enable && standby)
      else $error("enables active in standby");

   field_write_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE4
      wr_pwr && en_s && !host_stop |=> ##1 field_drive_enable == $past(host_wdata[5], 2))
      else $error("field enable does not follow written bit");

   keying_path_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE3
      pwr_r.direct |=> mod_out == $past(key_s))
      else $error("modulation not driven from keying input");

   crc_sel_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE10
      wr_proto && en_s |=> ##1 crc_check_enable == !$past(host_wdata[7], 2))
      else $error("crc check does not follow written bit");

   reload_pulse_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE19
      wr_proto && en_s |=> option_reload ##1 (option_reload == $past(wr_proto && en_s)))
      else $error("option reload pulse wrong");

   stop_clear_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE20
      host_stop |=> !pwr_r.direct ##1 !decoder_bypass && !raw_out_oe)
      else $error("stop did not end raw path");

   raw_clock_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE11
      raw_clk_oe |-> decoder_bypass && raw_out_oe)
      else $error("bit clock driven outside raw bit mode");

   prox_rate_a: assert property (@(posedge clk) disable iff (!rst_sync_b) // RULE14
      proto_r.code[4:2] == 3'h2 |=> proto_info.family == rfm_pkg::RFM_PROX_A
                                    && rx_rate == $past(proto_r.code[1:0]))
      else $error("proximity A code decoded wrongly");

endmodule
`default_nettype wire

// ### rfm_host_model.sv
// host microcontroller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module rfm_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] host_rdata,
   input  wire logic       host_rvalid,
   input  wire logic       option_reload,
   output logic            host_wr,
   output logic            host_rd,
   output logic            host_stop,
   output logic [4:0]      host_addr,
   output logic [7:0]      host_wdata
);
   logic reload_seen;
   logic timed_out;
   // idle port at time zero
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_stop = 1'b0;
      host_addr = 5'h00;
      host_wdata = 8'h00;
      reload_seen = 1'b0;
      timed_out = 1'b0;
   end
   // released lines flip so stale values never look valid
   task automatic release_bus();
      host_addr = ~host_addr;
      host_wdata = ~host_wdata;
   endtask
   // one write cycle; reserved bits always go out as zero
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 5'h00) v[2] = 1'b0;
      if (a == 5'h01) v[5] = 1'b0;
      if (a == 5'h01 && v[4:0] > 5'h0F && v[4:0] != 5'h13) v[4:0] = 5'h02;
      @(posedge clk);
      #1;
      host_addr = a;
      host_wdata = v;
      host_wr = 1'b1;
      @(posedge clk);
      #1;
      host_wr = 1'b0;
      reload_seen = option_reload;
      release_bus();
   endtask
   // one read cycle, bounded wait for the answer
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      host_addr = a;
      host_rd = 1'b1;
      @(posedge clk);
      #1;
      host_rd = 1'b0;
      while (host_rvalid !== 1'b1 && n < 4) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (host_rvalid !== 1'b1) timed_out = 1'b1;
      d = host_rdata;
      release_bus();
   endtask
   // stop condition ends the raw path
   task automatic stop();
      @(posedge clk);
      #1;
      host_stop = 1'b1;
      @(posedge clk);
      #1;
      host_stop = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the main configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
   $display("unexpected %s expected %0h seen %0h", nm, exp, got); error_cnt++; end end
module testbench;
   logic clk, rst_b, chip_en, host_wr, host_rd, host_stop, host_rvalid;
   logic [4:0] host_addr;
   logic [7:0] host_wdata, host_rdata, v, outs;
   logic am_input, pm_input, keying_input, framer_mod, dec_bit, dec_bit_clk, tx_rate_differs;
   logic [1:0] tx_rate_sel, rx_rate, tx_rate;
   logic standby, rx_enable, tx_enable, osc_enable, field_drive_enable, drive_strength_half;
   logic phase_input_select, supply_range_select, decoder_bypass, mod_out, raw_out, raw_out_oe;
   logic raw_clk_out, raw_clk_oe, crc_check_enable, option_reload;
   logic [4:0] code;
   rfm_pkg::rfm_info_type proto_info, exp_info;
   int error_cnt, comparisons;
   logic [7:0] pwr_vals [9] = '{8'h80, 8'hA2, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01, 8'h40, 8'h00};

   rfm_main_cfg DUT (.clk, .rst_b, .chip_en, .host_wr, .host_rd, .host_stop, .host_addr, .host_wdata,
      .host_rdata, .host_rvalid, .am_input, .pm_input, .keying_input, .framer_mod, .dec_bit,
      .dec_bit_clk, .tx_rate_differs, .tx_rate_sel, .standby, .rx_enable, .tx_enable, .osc_enable,
      .field_drive_enable, .drive_strength_half, .phase_input_select, .supply_range_select,
      .decoder_bypass, .mod_out, .raw_out, .raw_out_oe, .raw_clk_out, .raw_clk_oe,
      .crc_check_enable, .proto_info, .rx_rate, .tx_rate, .option_reload);
   rfm_host_model u_host (.clk, .host_rdata, .host_rvalid, .option_reload, .host_wr, .host_rd,
      .host_stop, .host_addr, .host_wdata);

   // free-running 125 MHz clock
   always #4 clk = ~clk;

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // read and compare; a missing answer ends the run
   task automatic rdchk(input logic [4:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      u_host.rd(a, d);
      // a missing answer is a mismatch and goes straight to the verdict
      if (u_host.timed_out) begin
         error_cnt++;
         print_verdict();
      end else begin
         `CHK(nm, e, d)
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      {clk, rst_b, chip_en, am_input, pm_input, keying_input, framer_mod} = 7'h10;
      {dec_bit, dec_bit_clk, tx_rate_differs, tx_rate_sel} = 5'h00;
      error_cnt = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      #1;
      rst_b = 1'b1;
      settle(10);
      // reset contents
      rdchk(5'h00, 8'h01, "pwr reset");
      rdchk(5'h01, 8'h02, "proto reset");
      `CHK("crc on", 1'b1, crc_check_enable)
      $display("test reset done");
      // each power bit against the outputs it drives
      foreach (pwr_vals[i]) begin
         v = pwr_vals[i];
         u_host.wr(5'h00, v);
         settle(2);
         outs = {standby, decoder_bypass, field_drive_enable, drive_strength_half, phase_input_select,
            rx_enable, tx_enable, supply_range_select};
         `CHK("pwr bits", v[7:3], outs[7:3])
         `CHK("pwr enables", {~v[7] & (v[5] | v[1]), ~v[7] & v[5], v[0]}, outs[2:0])
         `CHK("osc", 1'b1, osc_enable)
         rdchk(5'h00, v, "pwr readback");
      end
      $display("test power bits done");
      // every defined protocol code plus the proprietary one
      for (int c = 0; c <= 16; c++) begin
         code = (c == 16) ? 5'h13 : c[4:0];
         u_host.wr(5'h01, {3'h0, code});
         `CHK("reload", 1'b1, u_host.reload_seen)
         settle(2);
         if (code == 5'h13) exp_info = '{rfm_pkg::RFM_PROPR, 2'h0, 1'b0};
         else if (code < 5'h08) exp_info = '{(code[2] ? rfm_pkg::RFM_VIC_DOUBLE : rfm_pkg::RFM_VIC_SINGLE),
            {1'b0, code[1]}, code[0]};
         else exp_info = '{(code[2] ? rfm_pkg::RFM_PROX_B : rfm_pkg::RFM_PROX_A), code[1:0], 1'b0};
         `CHK("family", exp_info.family, proto_info.family)
         if (code != 5'h13) `CHK("rate coding", exp_info, proto_info)
         if (code != 5'h13) `CHK("rx_rate", exp_info.rate, rx_rate)
         if (code != 5'h13) `CHK("tx_rate", exp_info.rate, tx_rate)
      end
      $display("test protocol codes done");
      // raw path: keying, receive inputs, decoder stream, stop
      {am_input, pm_input, keying_input, framer_mod, dec_bit, dec_bit_clk} = 6'h1B;
      {tx_rate_differs, tx_rate_sel} = 3'h7;
      u_host.wr(5'h00, 8'h48);
      settle(4);
      `CHK("raw am pm", 4'hE, {mod_out, raw_out, raw_out_oe, raw_clk_oe})
      u_host.wr(5'h01, 8'hC9);
      settle(2);
      `CHK("raw bits", 4'h7, {crc_check_enable, raw_out, raw_clk_out, raw_clk_oe})
      `CHK("rates", 4'h7, {rx_rate, tx_rate})
      rdchk(5'h01, 8'hC9, "proto readback");
      u_host.stop();
      settle(2);
      `CHK("stop", 3'h0, {decoder_bypass, raw_out_oe, mod_out})
      rdchk(5'h00, 8'h08, "pwr after stop");
      $display("test raw path done");
      // chip enable low clears both registers and blocks writes
      u_host.wr(5'h01, 8'h0C);
      chip_en = 1'b0;
      settle(5);
      u_host.wr(5'h00, 8'h20);
      `CHK("osc off", 1'b0, osc_enable)
      chip_en = 1'b1;
      settle(6);
      rdchk(5'h00, 8'h01, "pwr cleared");
      rdchk(5'h01, 8'h02, "proto cleared");
      rdchk(5'h05, 8'h00, "unmapped read");
      $display("test chip enable done");
      print_verdict();
   end
endmodule
`default_nettype wire
